/* File: charger_cfg_pkg.sv */
// shared offsets, reset values, field layout and timing counts for the charger config bank
package charger_cfg_pkg;

    // register offsets on the two-wire port
    localparam logic [7:0] REG_TIMER_CTRL = 8'h05;
    localparam logic [7:0] REG_IRQ_MASK   = 8'h06;
    localparam logic [7:0] REG_THERM_SYS  = 8'h07;

    // power-on / register-reset values
    localparam logic [7:0] RST_TIMER_CTRL = 8'h18;
    localparam logic [7:0] RST_IRQ_MASK   = 8'hC0;
    localparam logic [7:0] RST_THERM_SYS  = 8'hB9;

    // writable bits (the watchdog bits at the top of the timer register are not held here)
    localparam logic [7:0] WR_TIMER_CTRL  = 8'h1F;
    localparam logic [7:0] WR_IRQ_MASK    = 8'hFF;
    localparam logic [7:0] WR_THERM_SYS   = 8'hFF;

    // bits that a watchdog expiry returns to default
    localparam logic [7:0] WD_TIMER_CTRL  = 8'h1F;
    localparam logic [7:0] WD_IRQ_MASK    = 8'hDF;
    localparam logic [7:0] WD_THERM_SYS   = 8'hF0;

    // timer control fields
    localparam int TERM_EN_BIT     = 4;
    localparam int TIMER_EN_BIT    = 3;
    localparam int TMO_SEL_LSB     = 1;
    localparam int POST_TERM_BIT   = 0;
    // mask register fields
    localparam int NTC_EN_BIT      = 7;
    localparam int TMR2X_BIT       = 6;
    localparam int SW_OFF_BIT      = 5;
    localparam int PG_MASK_BIT     = 4;
    localparam int EOC_MASK_BIT    = 3;
    localparam int STAT_MASK_BIT   = 2;
    localparam int NTC_MASK_BIT    = 1;
    localparam int OVP_MASK_BIT    = 0;
    // thermal / system regulation fields
    localparam int PCB_OTP_DIS_BIT = 7;
    localparam int VIN_LOOP_BIT    = 6;
    localparam int TJ_LSB          = 4;
    localparam int VSYS_LSB        = 0;

    // system regulation target
    localparam logic [12:0] VSYS_OFFSET_MV = 13'd4200;
    localparam logic [12:0] VSYS_STEP_MV   = 13'd50;

    // charge state codes reported by the charger core
    localparam logic [1:0] CHG_IDLE = 2'h0;
    localparam logic [1:0] CHG_PRE  = 2'h1;
    localparam logic [1:0] CHG_FAST = 2'h2;
    localparam logic [1:0] CHG_DONE = 2'h3;

    // safety timer
    localparam int SECS_PER_HOUR     = 3600;
    localparam int TMR_HOURS_0       = 20;
    localparam int TMR_HOURS_1       = 5;
    localparam int TMR_HOURS_2       = 8;
    localparam int TMR_HOURS_3       = 12;
    localparam longint SECOND_NS     = 1000000000;
    localparam longint CLK_PERIOD_NS = 10;
    localparam int SEC_CYCLES        = int'(SECOND_NS / CLK_PERIOD_NS);

    // two-wire device address, 7 bits
    localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h08;

    typedef struct packed {
        logic        terminationEnable;
        logic        safetyTimerEnable;
        logic [1:0]  fast_charge_timeout_select;
        logic        post_termination_timer_enable;
        logic        thermistor_monitor_enable;
        logic        timer_doubling_enable;
        logic        batterySwitchOn;
        logic        boardOvertempProtectEnable;
        logic        input_voltage_loop_disable;
        logic [1:0]  die_thermal_threshold;
        logic [3:0]  vsysCode;
        logic [12:0] vsysTargetMv;
    } charger_cfg_t;

    typedef struct packed {
        logic       powerGood;
        logic [1:0] chargeState;
        logic       thermistorFault;
        logic       batteryOvervoltage;
        logic       terminationReached;
        logic       power_path_limiting;
    } charger_status_t;

endpackage

/* File: pin_synchronizer.sv */
// three-stage pin synchroniser; the output follows once stages two and three agree
`timescale 1ns/1ps
module pin_synchronizer #(
    parameter int WIDTH = 1
) (
    input  wire logic             ref_clk,
    input  wire logic             nrst,
    input  wire logic [WIDTH-1:0] pinIn,
    output logic      [WIDTH-1:0] pinOut
);
    logic [WIDTH-1:0] stage1_ff;
    logic [WIDTH-1:0] stage2_ff;
    logic [WIDTH-1:0] stage3_ff;

    // idle two-wire lines sit high, so reset to the released level
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            stage1_ff <= '1;
            stage2_ff <= '1;
            stage3_ff <= '1;
        end else begin
            stage1_ff <= pinIn;
            stage2_ff <= stage1_ff;
            stage3_ff <= stage2_ff;
        end
    end

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge ref_clk) begin
                if (!nrst) begin
                    pinOut[i] <= 1'b1;
                end else if (stage2_ff[i] == stage3_ff[i]) begin
                    pinOut[i] <= stage3_ff[i];
                end
            end
        end
    endgenerate
endmodule

/* File: charger_config_register_bank.sv */
// charger timer, mask and regulation registers behind a two-wire slave port
//
// What this block does
// - the safety-timer enable bit arms the charge safety timer when set and stops it when clear, and it powers up set.
// - the two-bit fast-charge timer field picks 20, 5, 8 or 12 hours for codes 00 to 11 and resets to 00.
// - with the post-termination timer bit set charge current keeps flowing after termination, else it is suspended while the termination enable bit is set.
// - the battery-switch disable bit turns the battery transistor off both ways, resets clear, and survives watchdog.
// - five mask bits silence the power-good, end-of-charge, state-change, thermistor and over-voltage interrupts.
// - an unmasked interrupt fires whenever the charger moves among not-charging, pre-charge and fast-charge.
// - the board over-temperature bit is inverted, zero enabling protection, and it powers up as one (disabled).
// - the die thermal threshold field picks 60, 80, 100 or 120 degrees and resets to 11.
// - the system voltage field sets 4.2 V plus 50 mV per step, resets to 1001, and survives watchdog expiry.
`timescale 1ns/1ps
module charger_config_register_bank
    import charger_cfg_pkg::*;
#(
    parameter int         SEC_TICKS = SEC_CYCLES,
    parameter logic [6:0] DEV_ADDR  = DEV_ADDR_DEFAULT
) (
    input  wire logic            ref_clk,
    input  wire logic            nrst,
    input  wire logic            sclIn,
    input  wire logic            sdaIn,
    output logic                 sdaOut,
    output logic                 sdaOe,
    input  wire logic            regResetReq,
    input  wire logic            watchdog_expiry,
    input  wire charger_status_t chgStatus,
    output charger_cfg_t         cfg,
    output logic                 chargeCurrentSuspend,
    output logic                 safetyTimerExpired,
    output logic                 irqPulse
);
    typedef enum logic [8:0] {
        S_IDLE   = 9'h001,
        S_ADDR   = 9'h002,
        S_AACK   = 9'h004,
        S_PTR    = 9'h008,
        S_PACK   = 9'h010,
        S_WDATA  = 9'h020,
        S_WACK   = 9'h040,
        S_RDATA  = 9'h080,
        S_RACK   = 9'h100
    } bus_state_t;

    ////////////////////////////////////////////////////////////////////////////////
    logic [1:0] linesSync;
    logic       sclPrev_ff;
    logic       sdaPrev_ff;

    pin_synchronizer #(.WIDTH(2)) u_sync (
        .ref_clk (ref_clk),
        .nrst    (nrst),
        .pinIn   ({sclIn, sdaIn}),
        .pinOut  (linesSync)
    );

    wire scl      = linesSync[1];
    wire sda      = linesSync[0];
    wire sclRise  = scl & ~sclPrev_ff;
    wire sclFall  = ~scl & sclPrev_ff;
    wire startCnd = scl & sclPrev_ff & sdaPrev_ff & ~sda;
    wire stopCnd  = scl & sclPrev_ff & ~sdaPrev_ff & sda;

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            sclPrev_ff <= 1'b1;
            sdaPrev_ff <= 1'b1;
        end else begin
            sclPrev_ff <= scl;
            sdaPrev_ff <= sda;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    bus_state_t state_ff;
    logic [3:0] bitCnt_ff;
    logic [7:0] shift_ff;
    logic [7:0] ptr_ff;
    logic       readDir_ff;
    logic       masterAck_ff;
    logic       sdaOe_ff;
    logic [7:0] timerCtrl_ff;
    logic [7:0] irqMask_ff;
    logic [7:0] thermSys_ff;

    function automatic logic [7:0] read_reg(input logic [7:0] addr, input logic [7:0] t,
                                            input logic [7:0] m, input logic [7:0] s);
        unique case (addr)
            REG_TIMER_CTRL: read_reg = t;
            REG_IRQ_MASK:   read_reg = m;
            REG_THERM_SYS:  read_reg = s;
            default:        read_reg = 8'h00;
        endcase
    endfunction

    // one register value after a write and the two reset sources; reset requests beat a write
    function automatic logic [7:0] update_reg(input logic [7:0] cur, input logic [7:0] rstVal,
                                              input logic [7:0] wrMask, input logic [7:0] wdMask,
                                              input logic hit, input logic [7:0] data,
                                              input logic regRst, input logic wdExp);
        logic [7:0] v;
        v = cur;
        if (hit) v = (cur & ~wrMask) | (data & wrMask);
        if (wdExp) v = (v & ~wdMask) | (rstVal & wdMask);
        if (regRst) v = rstVal;
        update_reg = v;
    endfunction

    wire [7:0] readData  = read_reg(ptr_ff, timerCtrl_ff, irqMask_ff, thermSys_ff);
    wire [7:0] nextRead  = read_reg(ptr_ff + 8'h01, timerCtrl_ff, irqMask_ff, thermSys_ff);
    wire       byteDone  = (bitCnt_ff == 4'h8);
    wire       wrStrobe  = (state_ff == S_WDATA) && sclFall && byteDone;

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            state_ff     <= S_IDLE;
            bitCnt_ff    <= 4'h0;
            shift_ff     <= 8'h00;
            ptr_ff       <= 8'h00;
            readDir_ff   <= 1'b0;
            masterAck_ff <= 1'b0;
            sdaOe_ff     <= 1'b0;
        end else if (startCnd) begin
            state_ff  <= S_ADDR;
            bitCnt_ff <= 4'h0;
            sdaOe_ff  <= 1'b0;
        end else if (stopCnd) begin
            state_ff <= S_IDLE;
            sdaOe_ff <= 1'b0;
        end else if (sclRise) begin
            if (state_ff == S_RACK) begin
                masterAck_ff <= ~sda;
            end else if (state_ff inside {S_ADDR, S_PTR, S_WDATA, S_RDATA}) begin
                bitCnt_ff <= bitCnt_ff + 4'h1;
                if (state_ff != S_RDATA) shift_ff <= {shift_ff[6:0], sda};
            end
        end else if (sclFall) begin
            unique case (state_ff)
                S_IDLE: begin
                    sdaOe_ff <= 1'b0;
                end
                S_ADDR: begin
                    if (byteDone) begin
                        if (shift_ff[7:1] == DEV_ADDR) begin
                            state_ff   <= S_AACK;
                            readDir_ff <= shift_ff[0];
                            sdaOe_ff   <= 1'b1;
                        end else begin
                            state_ff <= S_IDLE;
                        end
                    end
                end
                S_AACK: begin
                    bitCnt_ff <= 4'h0;
                    if (readDir_ff) begin
                        state_ff <= S_RDATA;
                        shift_ff <= readData;
                        sdaOe_ff <= ~readData[7];
                    end else begin
                        state_ff <= S_PTR;
                        sdaOe_ff <= 1'b0;
                    end
                end
                S_PTR: begin
                    if (byteDone) begin
                        ptr_ff   <= shift_ff;
                        state_ff <= S_PACK;
                        sdaOe_ff <= 1'b1;
                    end
                end
                S_WDATA: begin
                    if (byteDone) begin
                        ptr_ff   <= ptr_ff + 8'h01;
                        state_ff <= S_WACK;
                        sdaOe_ff <= 1'b1;
                    end
                end
                S_PACK, S_WACK: begin
                    state_ff  <= S_WDATA;
                    bitCnt_ff <= 4'h0;
                    sdaOe_ff  <= 1'b0;
                end
                S_RDATA: begin
                    if (byteDone) begin
                        state_ff <= S_RACK;
                        sdaOe_ff <= 1'b0;
                    end else begin
                        shift_ff <= {shift_ff[6:0], 1'b0};
                        sdaOe_ff <= ~shift_ff[6];
                    end
                end
                S_RACK: begin
                    // a master nack ends the read; the pointer only advances on ack
                    if (masterAck_ff) begin
                        ptr_ff    <= ptr_ff + 8'h01;
                        shift_ff  <= nextRead;
                        sdaOe_ff  <= ~nextRead[7];
                        bitCnt_ff <= 4'h0;
                        state_ff  <= S_RDATA;
                    end else begin
                        state_ff <= S_IDLE;
                    end
                end
            endcase
        end
    end

    assign sdaOut = 1'b0;
    assign sdaOe  = sdaOe_ff;

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge ref_clk) begin
        if (!nrst) timerCtrl_ff <= RST_TIMER_CTRL;
        else timerCtrl_ff <= update_reg(timerCtrl_ff, RST_TIMER_CTRL, WR_TIMER_CTRL, WD_TIMER_CTRL,
                                        wrStrobe && ptr_ff == REG_TIMER_CTRL, shift_ff,
                                        regResetReq, watchdog_expiry);
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) irqMask_ff <= RST_IRQ_MASK;
        else irqMask_ff <= update_reg(irqMask_ff, RST_IRQ_MASK, WR_IRQ_MASK, WD_IRQ_MASK,
                                      wrStrobe && ptr_ff == REG_IRQ_MASK, shift_ff,
                                      regResetReq, watchdog_expiry);
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) thermSys_ff <= RST_THERM_SYS;
        else thermSys_ff <= update_reg(thermSys_ff, RST_THERM_SYS, WR_THERM_SYS, WD_THERM_SYS,
                                       wrStrobe && ptr_ff == REG_THERM_SYS, shift_ff,
                                       regResetReq, watchdog_expiry);
    end

    always_comb begin
        cfg.terminationEnable             = timerCtrl_ff[TERM_EN_BIT];
        cfg.safetyTimerEnable             = timerCtrl_ff[TIMER_EN_BIT];
        cfg.fast_charge_timeout_select    = timerCtrl_ff[TMO_SEL_LSB +: 2];
        cfg.post_termination_timer_enable = timerCtrl_ff[POST_TERM_BIT];
        cfg.thermistor_monitor_enable     = irqMask_ff[NTC_EN_BIT];
        cfg.timer_doubling_enable         = irqMask_ff[TMR2X_BIT];
        cfg.batterySwitchOn               = ~irqMask_ff[SW_OFF_BIT];
        cfg.boardOvertempProtectEnable    = ~thermSys_ff[PCB_OTP_DIS_BIT];
        cfg.input_voltage_loop_disable    = thermSys_ff[VIN_LOOP_BIT];
        cfg.die_thermal_threshold         = thermSys_ff[TJ_LSB +: 2];
        cfg.vsysCode                      = thermSys_ff[VSYS_LSB +: 4];
        cfg.vsysTargetMv                  = VSYS_OFFSET_MV + VSYS_STEP_MV * {9'h000, thermSys_ff[3:0]};
    end

    // with termination enabled, charge is held off at termination unless the post-termination timer keeps it on
    assign chargeCurrentSuspend = cfg.terminationEnable & chgStatus.terminationReached
                                  & ~cfg.post_termination_timer_enable;

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [16:0] timeout_secs(input logic [1:0] sel);
        unique case (sel)
            2'h0: timeout_secs = 17'(TMR_HOURS_0 * SECS_PER_HOUR);
            2'h1: timeout_secs = 17'(TMR_HOURS_1 * SECS_PER_HOUR);
            2'h2: timeout_secs = 17'(TMR_HOURS_2 * SECS_PER_HOUR);
            2'h3: timeout_secs = 17'(TMR_HOURS_3 * SECS_PER_HOUR);
        endcase
    endfunction

    logic [31:0] prescale_ff;
    logic        halfPhase_ff;
    logic [16:0] seconds_ff;
    logic        expired_ff;

    wire charging  = chgStatus.chargeState inside {CHG_PRE, CHG_FAST};
    wire timerRun  = cfg.safetyTimerEnable & charging;
    wire secTick   = timerRun && prescale_ff == 32'(SEC_TICKS - 1);
    wire slowMode  = chgStatus.power_path_limiting & cfg.timer_doubling_enable;
    wire secCount  = secTick & (~slowMode | halfPhase_ff);

    always_ff @(posedge ref_clk) begin
        if (!nrst || !timerRun) begin
            prescale_ff  <= 32'h0000_0000;
            halfPhase_ff <= 1'b0;
        end else begin
            prescale_ff  <= secTick ? 32'h0000_0000 : prescale_ff + 32'h0000_0001;
            halfPhase_ff <= secTick ? ~halfPhase_ff : halfPhase_ff;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst || !timerRun) begin
            seconds_ff <= 17'h00000;
            expired_ff <= 1'b0;
        end else if (secCount && !expired_ff) begin
            seconds_ff <= seconds_ff + 17'h00001;
            expired_ff <= (seconds_ff + 17'h00001) >= timeout_secs(cfg.fast_charge_timeout_select);
        end
    end

    assign safetyTimerExpired = expired_ff;

    ////////////////////////////////////////////////////////////////////////////////
    logic       pgPrev_ff;
    logic [1:0] statePrev_ff;
    logic       ntcPrev_ff;
    logic       ovpPrev_ff;
    logic       irq_ff;

    wire evPg   = chgStatus.powerGood ^ pgPrev_ff;
    wire evEoc  = chgStatus.chargeState == CHG_DONE && statePrev_ff != CHG_DONE;
    wire evStat = chgStatus.chargeState != statePrev_ff && chgStatus.chargeState != CHG_DONE
                  && statePrev_ff != CHG_DONE;
    wire evNtc  = chgStatus.thermistorFault & ~ntcPrev_ff;
    wire evOvp  = chgStatus.batteryOvervoltage & ~ovpPrev_ff;
    wire irqAny = (evPg & ~irqMask_ff[PG_MASK_BIT]) | (evEoc & ~irqMask_ff[EOC_MASK_BIT])
                | (evStat & ~irqMask_ff[STAT_MASK_BIT]) | (evNtc & ~irqMask_ff[NTC_MASK_BIT])
                | (evOvp & ~irqMask_ff[OVP_MASK_BIT]);

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            pgPrev_ff    <= 1'b0;
            statePrev_ff <= CHG_IDLE;
            ntcPrev_ff   <= 1'b0;
            ovpPrev_ff   <= 1'b0;
            irq_ff       <= 1'b0;
        end else begin
            pgPrev_ff    <= chgStatus.powerGood;
            statePrev_ff <= chgStatus.chargeState;
            ntcPrev_ff   <= chgStatus.thermistorFault;
            ovpPrev_ff   <= chgStatus.batteryOvervoltage;
            irq_ff       <= irqAny;
        end
    end

    assign irqPulse = irq_ff;

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    sequence s_wd_only;
        watchdog_expiry && !regResetReq && !wrStrobe;
    endsequence

    a_timer_disable_stops: assert property (!cfg.safetyTimerEnable |=> seconds_ff == 17'h00000)
        else $error("safety timer counted while disabled");
    a_timeout_code_hours: assert property ($rose(expired_ff)
        |-> seconds_ff == timeout_secs(cfg.fast_charge_timeout_select))
        else $error("safety timer expired at wrong count");
    a_suspend_at_term: assert property (chgStatus.terminationReached && cfg.terminationEnable
        |-> chargeCurrentSuspend == !cfg.post_termination_timer_enable)
        else $error("termination suspend wrong");
    a_switch_keeps_wd: assert property (s_wd_only |=> $stable(irqMask_ff[SW_OFF_BIT]))
        else $error("battery switch bit restored by watchdog");
    a_mask_silences_irq: assert property (##1 &irqMask_ff[4:0] |=> !irqPulse)
        else $error("interrupt raised while all masked");
    a_state_change_irq: assert property (evStat && !irqMask_ff[STAT_MASK_BIT] |=> irqPulse)
        else $error("charge state change did not interrupt");
    // written bit against the decoded enable, so a dropped inversion is caught
    a_otp_inverted: assert property (wrStrobe && ptr_ff == REG_THERM_SYS && !regResetReq && !watchdog_expiry
        |=> cfg.boardOvertempProtectEnable == !$past(shift_ff[PCB_OTP_DIS_BIT]))
        else $error("board protect polarity wrong");
    a_reg_reset_vals: assert property (regResetReq |=> thermSys_ff == RST_THERM_SYS
        && irqMask_ff == RST_IRQ_MASK && cfg.die_thermal_threshold == 2'h3)
        else $error("register reset values wrong");
    a_vsys_keeps_wd: assert property (s_wd_only |=> $stable(thermSys_ff[3:0])
        && cfg.vsysTargetMv == VSYS_OFFSET_MV + VSYS_STEP_MV * {9'h000, cfg.vsysCode})
        else $error("system voltage field restored by watchdog");
    a_half_rate_limit: assert property (secTick && slowMode && !halfPhase_ff && !expired_ff
        |=> $stable(seconds_ff))
        else $error("timer not slowed in power-path limiting");
endmodule

/* File: host_model.sv */
// two-wire host master model driving the charger register bank
`timescale 1ns/1ps
module host_model (
    input  wire logic ref_clk,
    input  wire logic sdaWire,
    output logic      scl,
    output logic      sdaLow
);
    initial begin
        scl = 1'b1;
        sdaLow = 1'b0;
    end
    task automatic hold(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    // sda moves 5 cycles after scl falls so the slave never sees a false start or stop
    task automatic put(input logic b, output logic r);
        hold(5);
        sdaLow <= ~b;
        hold(20);
        scl <= 1'b1;
        hold(13);
        r = sdaWire;
        hold(12);
        scl <= 1'b0;
    endtask
    task automatic byte_out(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) put(d[i], r);
        put(1'b1, r);
        ack = ~r;
    endtask
    task automatic byte_in(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            put(1'b1, r);
            d[i] = r;
        end
        put(last, r);
    endtask
    task automatic start();
        hold(5);
        sdaLow <= 1'b0;
        hold(20);
        scl <= 1'b1;
        hold(25);
        sdaLow <= 1'b1;
        hold(25);
        scl <= 1'b0;
    endtask
    task automatic stop();
        hold(5);
        sdaLow <= 1'b1;
        hold(20);
        scl <= 1'b1;
        hold(25);
        sdaLow <= 1'b0;
        hold(25);
    endtask
endmodule

/* File: test_charger_config_register_bank.sv */
// self-checking bench for the charger config register bank
`timescale 1ns/1ps
module test_charger_config_register_bank;
    import charger_cfg_pkg::*;
    logic ref_clk, nrst, regResetReq, watchdog_expiry, scl, sdaLow, sdaOut, sdaOe, sdaWire;
    logic chargeCurrentSuspend, safetyTimerExpired, irqPulse;
    logic [7:0] d;
    charger_status_t chgStatus;
    charger_cfg_t cfg;
    int n_mismatch = 0;
    int tests_run = 0;
    int irqCount = 0;
    int c0;
    // open-drain data line with pull-up
    assign sdaWire = ~(sdaOe | sdaLow);
    host_model host_model_inst (.ref_clk(ref_clk), .sdaWire(sdaWire), .scl(scl), .sdaLow(sdaLow));
    charger_config_register_bank #(.SEC_TICKS(1)) charger_config_register_bank_inst (.ref_clk(ref_clk),
        .nrst(nrst), .sclIn(scl), .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOe(sdaOe), .regResetReq(regResetReq),
        .watchdog_expiry(watchdog_expiry), .chgStatus(chgStatus), .cfg(cfg),
        .chargeCurrentSuspend(chargeCurrentSuspend), .safetyTimerExpired(safetyTimerExpired), .irqPulse(irqPulse));
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) if (irqPulse === 1'b1) irqCount <= irqCount + 1;
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic hdr(input logic [7:0] a);
        logic k;
        host_model_inst.start();
        host_model_inst.byte_out({DEV_ADDR_DEFAULT, 1'b0}, k);
        host_model_inst.byte_out(a, k);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        logic k;
        hdr(a);
        host_model_inst.byte_out(v, k);
        host_model_inst.stop();
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        logic k;
        hdr(a);
        host_model_inst.start();
        host_model_inst.byte_out({DEV_ADDR_DEFAULT, 1'b1}, k);
        host_model_inst.byte_in(1'b1, v);
        host_model_inst.stop();
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        #800000;
        n_mismatch++;
        give_verdict();
    end
    initial begin
        nrst = 1'b0;
        regResetReq = 1'b0;
        watchdog_expiry = 1'b0;
        chgStatus = '0;
        repeat (2) @(posedge ref_clk);
        nrst <= 1'b1;
        repeat (10) @(posedge ref_clk);
        rd(REG_TIMER_CTRL, d);
        chk(d, 16'h18);
        rd(REG_IRQ_MASK, d);
        chk(d, 16'hC0);
        rd(REG_THERM_SYS, d);
        chk(d, 16'hB9);
        chk(cfg.vsysTargetMv, 16'd4650);
        chk(cfg.boardOvertempProtectEnable, 16'h0);
        d = {2'b00, sdaOut, cfg.terminationEnable, cfg.safetyTimerEnable, cfg.thermistor_monitor_enable,
             cfg.timer_doubling_enable, cfg.input_voltage_loop_disable};
        chk(d, 16'h1E);
        $display("reset values done");
        wr(REG_THERM_SYS, 8'h0F);
        chk(cfg.vsysTargetMv, 16'd4200 + 16'd50 * 16'd15);
        chk(cfg.boardOvertempProtectEnable, 16'h1);
        chk(cfg.die_thermal_threshold, 16'h0);
        wr(REG_IRQ_MASK, 8'h3F);
        chk(cfg.batterySwitchOn, 16'h0);
        @(posedge ref_clk) watchdog_expiry <= 1'b1;
        @(posedge ref_clk) watchdog_expiry <= 1'b0;
        rd(REG_IRQ_MASK, d);
        chk(d, 16'hE0);
        rd(REG_THERM_SYS, d);
        chk(d, 16'hBF);
        @(posedge ref_clk) regResetReq <= 1'b1;
        @(posedge ref_clk) regResetReq <= 1'b0;
        rd(REG_IRQ_MASK, d);
        chk(d, 16'hC0);
        chk(cfg.vsysCode, 16'h9);
        $display("watchdog and reset command done");
        c0 = irqCount;
        @(posedge ref_clk) chgStatus.chargeState <= CHG_PRE;
        repeat (5) @(posedge ref_clk);
        chk(16'(irqCount - c0), 16'd1);
        wr(REG_IRQ_MASK, 8'hC4);
        c0 = irqCount;
        @(posedge ref_clk) chgStatus.chargeState <= CHG_FAST;
        repeat (5) @(posedge ref_clk);
        chk(16'(irqCount - c0), 16'd0);
        @(posedge ref_clk) chgStatus.powerGood <= 1'b1;
        repeat (5) @(posedge ref_clk);
        chk(16'(irqCount - c0), 16'd1);
        // thermistor, over-voltage and end-of-charge stay unmasked under 0xC4
        @(posedge ref_clk) chgStatus.thermistorFault <= 1'b1;
        repeat (5) @(posedge ref_clk);
        @(posedge ref_clk) chgStatus.batteryOvervoltage <= 1'b1;
        repeat (5) @(posedge ref_clk);
        @(posedge ref_clk) chgStatus.chargeState <= CHG_DONE;
        repeat (5) @(posedge ref_clk);
        chk(16'(irqCount - c0), 16'd4);
        $display("interrupt masking done");
        @(posedge ref_clk) chgStatus.terminationReached <= 1'b1;
        chgStatus.chargeState <= CHG_IDLE;
        repeat (2) @(posedge ref_clk);
        chk(chargeCurrentSuspend, 16'h1);
        // top bits are not held, so 0xFB reads back as 0x1B
        wr(REG_TIMER_CTRL, 8'hFB);
        chk(chargeCurrentSuspend, 16'h0);
        rd(REG_TIMER_CTRL, d);
        chk(d, 16'h1B);
        @(posedge ref_clk) chgStatus.power_path_limiting <= 1'b1;
        chgStatus.chargeState <= CHG_FAST;
        // five hours at one tick per second, doubled in power-path limiting
        repeat (35900) @(posedge ref_clk);
        chk(safetyTimerExpired, 16'h0);
        repeat (200) @(posedge ref_clk);
        chk(safetyTimerExpired, 16'h1);
        wr(REG_TIMER_CTRL, 8'h13);
        chk(safetyTimerExpired, 16'h0);
        $display("safety timer done");
        give_verdict();
    end
endmodule
